// ### dv/mmd_core_model.sv
`timescale 1ns/100ps

module mmd_core_model (
    input wire logic i_clk,
    output logic o_fetch_req,
    output logic [23:0] o_fetch_addr,
    output logic o_data_req,
    output logic [23:0] o_data_addr,
    output logic o_data_wr,
    output logic o_data_word,
    output logic o_data_bitop,
    output logic o_data_gpr,
    output logic [23:0] o_cp,
    output logic [3:0] o_gpr_num
);
    initial begin
        {o_fetch_req, o_data_req, o_data_wr, o_data_word, o_data_bitop, o_data_gpr} = 6'h0;
        {o_fetch_addr, o_data_addr, o_cp, o_gpr_num} = 76'h0;
    end

    // at most one fetch and one data access per call; m = {gpr, bitop, word, wr}
    // software side never touches unused register addresses
    task go(input f, input [23:0] fa, input d, input [23:0] da, input [3:0] m,
            input [23:0] cp, input [3:0] n);
        @(posedge i_clk);
        o_fetch_req <= f;
        o_fetch_addr <= fa;
        o_data_req <= d;
        o_data_addr <= da;
        {o_data_gpr, o_data_bitop, o_data_word, o_data_wr} <= m;
        o_cp <= cp;
        o_gpr_num <= n;
        @(posedge i_clk);
        o_fetch_req <= 1'b0;
        o_data_req <= 1'b0;
        // released address lines must not keep their old value
        o_fetch_addr <= ~fa;
        o_data_addr <= ~da;
    endtask
endmodule // mmd_core_model

// ### dv/mmd_router_bench.sv
`timescale 1ns/100ps
`include "mmd_map.vh"

module mmd_router_bench;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_has_ext_bus = 1'b1, i_sys_mode = 1'b1;
    wire i_fetch_req, i_data_req, i_data_wr, i_data_word, i_data_bitop, i_data_gpr;
    wire [23:0] i_fetch_addr, i_data_addr, i_cp;
    wire [3:0] i_gpr_num;
    logic [15:0] i_program_sram_wp_size = 16'h0100, i_pw_word = 16'h0;
    logic [207:0] i_flash_wp = 208'h0;
    logic [63:0] i_password = 64'h4d2c_0b1a_7f3e_55aa;
    logic i_flash_rd_prot = 1'b0, i_pw_valid = 1'b0, i_relock = 1'b0;
    logic o_fetch_valid, o_fetch_ecc, o_fetch_sysbus, o_fetch_noopt, o_fetch_trap;
    logic o_data_valid, o_data_wr, o_data_word, o_data_bitop, o_data_ecc, o_data_sysbus;
    logic o_data_noopt, o_data_trap, o_data_wait, o_flash_unlocked;
    logic [13:0] o_fetch_sel, o_data_sel;
    logic [23:0] o_fetch_addr, o_data_addr;
    logic [19:0] o_fetch_line, o_data_line;
    logic [7:0] o_data_seg, o_data_sector;
    logic [4:0] o_data_block;
    logic [1:0] o_data_page;
    int fails = 0, num_checks = 0, cyc = 0;

    mmd_router DUT (.*);
    mmd_core_model core (.i_clk, .o_fetch_req(i_fetch_req), .o_fetch_addr(i_fetch_addr),
        .o_data_req(i_data_req), .o_data_addr(i_data_addr), .o_data_wr(i_data_wr),
        .o_data_word(i_data_word), .o_data_bitop(i_data_bitop), .o_data_gpr(i_data_gpr),
        .o_cp(i_cp), .o_gpr_num(i_gpr_num));

    always #2 i_clk = ~i_clk;

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task summarize;
        if (fails == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            summarize;
        end
    end

    task fe(input [23:0] a);
        core.go(1'b1, a, 1'b0, 24'h0, 4'h0, 24'h0, 4'h0);
        #1;
    endtask

    task da(input [23:0] a, input [3:0] m);
        core.go(1'b0, 24'h0, 1'b1, a, m, 24'h00f600, 4'h0);
        #1;
    endtask

    task pw(input [15:0] w);
        @(posedge i_clk);
        i_pw_valid <= 1'b1;
        i_pw_word <= w;
    endtask

    task t_fetch_map;
        logic [23:0] ad [14] = '{24'hc00010, 24'hc40000, 24'hc80000, 24'hcc0000, 24'he00000,
            24'he80000, 24'h00a000, 24'h00f600, 24'h00fe00, 24'h00f000, 24'h00e000,
            24'h400000, 24'hffff00, 24'h008000};
        int ix [14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 11};
        for (int i = 0; i < 14; i++) begin
            fe(ad[i]);
            chk(o_fetch_valid, 1'b1);
            chk(o_fetch_sel, 14'h1 << ix[i]);
            chk(o_fetch_line, ad[i][23:4]);
            chk(o_fetch_addr, ad[i]);
            chk(o_fetch_ecc, ix[i] < 4);
            chk(o_fetch_sysbus, ix[i] > 5);
        end
    endtask

    task t_trap;
        @(posedge i_clk) i_has_ext_bus <= 1'b0;
        fe(24'hf00000);
        chk(o_fetch_sel, 14'h2000);
        fe(24'h008000);
        chk(o_fetch_trap, 1'b1);
        @(posedge i_clk) i_sys_mode <= 1'b0;
        fe(24'hc0f000);
        chk(o_fetch_trap, 1'b1);
        da(24'hc0f800, 4'h0);
        chk(o_data_trap, 1'b1);
        @(posedge i_clk) i_sys_mode <= 1'b1;
        fe(24'hc0f000);
        chk(o_fetch_sel, 14'h0001);
        @(posedge i_clk) i_has_ext_bus <= 1'b1;
        fe(24'h210000);
        chk(o_fetch_noopt, 1'b1);
        fe(24'h400000);
        chk(o_fetch_noopt, 1'b0);
    endtask

    task t_data;
        core.go(1'b0, 24'h0, 1'b1, 24'h0, 4'h9, 24'h00f800, 4'h5);
        #1;
        chk(o_data_addr, 24'h00f80a);
        chk(o_data_sel, 14'h0080);
        core.go(1'b0, 24'h0, 1'b1, 24'h0, 4'h8, 24'h00f800, 4'hb);
        #1;
        chk(o_data_addr, 24'h00f807);
        core.go(1'b0, 24'h0, 1'b1, 24'h0, 4'hb, 24'h00f800, 4'hf);
        #1;
        chk({o_data_word, o_data_wr, o_data_addr}, {2'b11, 24'h00f81e});
        core.go(1'b0, 24'h0, 1'b1, 24'h0, 4'hc, 24'h00f800, 4'h2);
        #1;
        chk({o_data_bitop, o_data_trap}, 2'b10);
        da(24'h00fd10, 4'h4);
        chk({o_data_valid, o_data_bitop, o_data_trap}, 3'b110);
        da(24'h00f700, 4'h4);
        chk(o_data_trap, 1'b1);
        da(24'h00a001, 4'h0);
        chk({o_data_word, o_data_sel}, {1'b0, 14'h0040});
        da(24'h210000, 4'h0);
        chk({o_data_noopt, o_data_sysbus, o_data_sel}, {2'b11, 14'h0800});
        da(24'h00fe02, 4'h2);
        chk({o_data_word, o_data_seg, o_data_sel}, {9'h100, 14'h0100});
        da(24'hc7c080, 4'h0);
        chk({o_data_seg, o_data_page}, {8'hc7, 2'h3});
        chk({o_data_sector, o_data_block}, {8'h7c, 5'h01});
        chk({o_data_ecc, o_data_sysbus, o_data_line}, {2'b11, 20'hc7c08});
    endtask

    task t_prot;
        @(posedge i_clk) i_flash_wp[124] <= 1'b1;
        da(24'hc7c080, 4'h1);
        chk(o_data_trap, 1'b1);
        da(24'hc7d000, 4'h1);
        chk({o_data_wr, o_data_sel}, {1'b1, 14'h0002});
        da(24'he00080, 4'h1);
        chk(o_data_trap, 1'b1);
        da(24'he00200, 4'h1);
        chk({o_data_sel, o_data_sysbus}, {14'h0010, 1'b1});
        @(posedge i_clk) i_flash_rd_prot <= 1'b1;
        da(24'hc00100, 4'h0);
        chk(o_data_trap, 1'b1);
        pw(16'h55aa);
        pw(16'h1234);
        pw(16'h7f3e);
        pw(16'h0b1a);
        pw(16'h4d2c);
        for (int k = 0; k < 4; k++)
            pw(i_password[16*k +: 16]);
        @(posedge i_clk) i_pw_valid <= 1'b0;
        #1;
        chk(o_flash_unlocked, 1'b1);
        da(24'hc00100, 4'h0);
        chk({o_data_sel, o_data_ecc}, {14'h0001, 1'b1});
        @(posedge i_clk) i_relock <= 1'b1;
        @(posedge i_clk) i_relock <= 1'b0;
        #1;
        chk(o_flash_unlocked, 1'b0);
        @(posedge i_clk) i_flash_rd_prot <= 1'b0;
    endtask

    task t_clash;
        core.go(1'b1, 24'hc00000, 1'b1, 24'hc10000, 4'h0, 24'h0, 4'h0);
        #1;
        chk({o_data_wait, o_data_valid, o_fetch_sel}, {2'b10, 14'h0001});
        core.go(1'b1, 24'hc00000, 1'b1, 24'hc40000, 4'h0, 24'h0, 4'h0);
        #1;
        chk({o_data_wait, o_data_valid, o_data_sel}, {2'b01, 14'h0002});
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_fetch_map;
        t_trap;
        t_data;
        t_prot;
        t_clash;
        summarize;
    end
endmodule // mmd_router_bench

// ### dv/mmd_router_monitor.sv
`timescale 1ns/100ps
`include "mmd_map.vh"

module mmd_router_monitor (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_has_ext_bus,
    input wire logic i_sys_mode,
    input wire logic i_fetch_req,
    input wire logic [23:0] i_fetch_addr,
    input wire logic i_data_req,
    input wire logic i_relock,
    input wire logic o_fetch_valid,
    input wire logic [13:0] o_fetch_sel,
    input wire logic [23:0] o_fetch_addr,
    input wire logic [19:0] o_fetch_line,
    input wire logic o_fetch_ecc,
    input wire logic o_fetch_noopt,
    input wire logic o_fetch_trap,
    input wire logic o_data_valid,
    input wire logic [13:0] o_data_sel,
    input wire logic [23:0] o_data_addr,
    input wire logic [7:0] o_data_seg,
    input wire logic [1:0] o_data_page,
    input wire logic o_data_wait,
    input wire logic o_flash_unlocked
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_fetch_ans;
        i_fetch_req |=> o_fetch_valid;
    endproperty
    a_fetch_ans: assert property (p_fetch_ans) else $error("fetch not answered");
    property p_fetch_idle;
        !i_fetch_req |=> !o_fetch_valid && o_fetch_sel == 14'h0;
    endproperty
    a_fetch_idle: assert property (p_fetch_idle) else $error("fetch out unasked");
    property p_fetch_one;
        o_fetch_valid |-> $onehot(o_fetch_sel) && o_fetch_trap == o_fetch_sel[13];
    endproperty
    a_fetch_one: assert property (p_fetch_one) else $error("fetch select not one-hot");
    property p_data_ans;
        i_data_req |=> o_data_valid != o_data_wait;
    endproperty
    a_data_ans: assert property (p_data_ans) else $error("data answer wrong");
    property p_data_one;
        o_data_valid |-> $onehot(o_data_sel);
    endproperty
    a_data_one: assert property (p_data_one) else $error("data select not one-hot");
    property p_geom;
        o_data_valid |-> o_data_seg == o_data_addr[23:16] && o_data_page == o_data_addr[15:14];
    endproperty
    a_geom: assert property (p_geom) else $error("segment or page wrong");
    property p_line;
        o_fetch_valid |-> o_fetch_line == o_fetch_addr[23:4]
            && o_fetch_ecc == (|o_fetch_sel[3:0]);
    endproperty
    a_line: assert property (p_line) else $error("fetch line or ecc wrong");
    property p_trap;
        i_fetch_req && !i_has_ext_bus && i_fetch_addr >= 24'hf00000
            && i_fetch_addr <= 24'hfffeff |=> o_fetch_trap;
    endproperty
    a_trap: assert property (p_trap) else $error("reserved fetch not trapped");
    property p_ext;
        i_fetch_req && i_has_ext_bus && i_fetch_addr[23:13] == 11'h004
            |=> o_fetch_sel == 14'h0800;
    endproperty
    a_ext: assert property (p_ext) else $error("reserved fetch not external");
    property p_noopt;
        o_fetch_valid && !o_fetch_trap |-> o_fetch_noopt ==
            (o_fetch_addr >= 24'h210000 && o_fetch_addr <= 24'h3fffff);
    endproperty
    a_noopt: assert property (p_noopt) else $error("io window flag wrong");
    property p_isec;
        i_fetch_req && !i_sys_mode && i_fetch_addr[23:12] == 12'hc0f |=> o_fetch_trap;
    endproperty
    a_isec: assert property (p_isec) else $error("internal sector open");
    property p_relock;
        i_relock |=> !o_flash_unlocked;
    endproperty
    a_relock: assert property (p_relock) else $error("flash not relocked");
endmodule // mmd_router_monitor

bind mmd_router mmd_router_monitor u_mon (.i_clk, .i_rstn, .i_has_ext_bus, .i_sys_mode,
    .i_fetch_req, .i_fetch_addr, .i_data_req, .i_relock, .o_fetch_valid, .o_fetch_sel,
    .o_fetch_addr, .o_fetch_line, .o_fetch_ecc, .o_fetch_noopt, .o_fetch_trap,
    .o_data_valid, .o_data_sel, .o_data_addr, .o_data_seg, .o_data_page, .o_data_wait,
    .o_flash_unlocked);

// ### logic/mmd_region_decode.v
`timescale 1ns/100ps
`include "mmd_map.vh"

module mmd_region_decode (
    input wire [`MMD_ADDR_W-1:0] i_addr,
    input wire i_has_ext_bus,
    output reg [`MMD_NTGT-1:0] o_sel,
    output wire o_reserved,
    output wire o_extio
);
    localparam [`MMD_NREG*`MMD_ADDR_W-1:0] REG_LO = `MMD_REGION_LO;
    localparam [`MMD_NREG*`MMD_ADDR_W-1:0] REG_HI = `MMD_REGION_HI;
    localparam [`MMD_NREG*`MMD_TGT_IDX_W-1:0] REG_TGT = `MMD_REGION_TGT;

    wire [`MMD_NREG-1:0] hit;
    integer k;

    genvar g;
    generate
        for (g = 0; g < `MMD_NREG; g = g + 1) begin : g_region
            // regions are disjoint, so at most one entry hits
            assign hit[g] = (i_addr >= REG_LO[g*`MMD_ADDR_W +: `MMD_ADDR_W]) &&
                            (i_addr <= REG_HI[g*`MMD_ADDR_W +: `MMD_ADDR_W]);
        end
    endgenerate

    assign o_reserved = ~|hit;
    assign o_extio = (i_addr >= `MMD_EXTIO_LO) && (i_addr <= `MMD_EXTIO_HI);

    always @* begin
        o_sel = `MMD_SEL_NONE;
        for (k = 0; k < `MMD_NREG; k = k + 1) begin
            if (hit[k]) begin
                o_sel[REG_TGT[k*`MMD_TGT_IDX_W +: `MMD_TGT_IDX_W]] = 1'b1;
            end
        end
        if (o_reserved) begin
            if (i_has_ext_bus) begin
                o_sel[`MMD_T_EXT] = 1'b1;
            end else begin
                o_sel[`MMD_T_TRAP] = 1'b1;
            end
        end
    end
endmodule // mmd_region_decode

// ### logic/mmd_router.v
`timescale 1ns/100ps
`include "mmd_map.vh"

// Overview of operation
// - fetches and data share one linear space and one decoder design
// - 16 Mbytes as 256 segments of 64K, four 16K pages each
// - byte and word accesses are accepted at every address
// - data memories and both register areas decode inside segment 0
// - reserved regions go to the external bus when the part has one
// - top 4K sector of flash segment 0 is internal, not user memory
// - external io region accesses run with pipeline optimizations off
// - all instruction fetches go through the program fetch unit
// - all data transfers go through the data transfer unit
// - two-way system bus carries both units' cross traffic concurrently
// - program sram via fetch unit, low region write-protect of programmable size
// - gpr bank of 16 words or 16 byte halves in dual-port ram
// - top 256 bytes of dual-port ram are bit-addressable
// - any dual-port ram location is bit-addressable when used as gpr
// - two 512-byte register areas of word-wide control registers
// - each flash module is split into 4K sectors
// - per-sector write protection, programming in 128-byte blocks
// - whole flash read-protectable for data reads (fetches ignore it), password sequence unlocks it temporarily
// - flash reads fetch 128-bit lines with error correction on every read
// - accesses to different flash modules may run in parallel
module mmd_router (
    input wire i_clk,
    input wire i_rstn,
    input wire i_has_ext_bus,
    input wire i_sys_mode,
    input wire i_fetch_req,
    input wire [`MMD_ADDR_W-1:0] i_fetch_addr,
    input wire i_data_req,
    input wire [`MMD_ADDR_W-1:0] i_data_addr,
    input wire i_data_wr,
    input wire i_data_word,
    input wire i_data_bitop,
    input wire i_data_gpr,
    input wire [`MMD_ADDR_W-1:0] i_cp,
    input wire [3:0] i_gpr_num,
    input wire [15:0] i_program_sram_wp_size,
    input wire [`MMD_NSECT-1:0] i_flash_wp,
    input wire i_flash_rd_prot,
    input wire [`MMD_PW_WORDS*`MMD_PW_W-1:0] i_password,
    input wire i_pw_valid,
    input wire [`MMD_PW_W-1:0] i_pw_word,
    input wire i_relock,
    output reg o_fetch_valid,
    output reg [`MMD_NTGT-1:0] o_fetch_sel,
    output reg [`MMD_ADDR_W-1:0] o_fetch_addr,
    output reg [`MMD_ADDR_W-`MMD_LINE_LSB-1:0] o_fetch_line,
    output reg o_fetch_ecc,
    output reg o_fetch_sysbus,
    output reg o_fetch_noopt,
    output reg o_fetch_trap,
    output reg o_data_valid,
    output reg [`MMD_NTGT-1:0] o_data_sel,
    output reg [`MMD_ADDR_W-1:0] o_data_addr,
    output reg o_data_wr,
    output reg o_data_word,
    output reg o_data_bitop,
    output reg [`MMD_SEG_W-1:0] o_data_seg,
    output reg [`MMD_PAGE_W-1:0] o_data_page,
    output reg [`MMD_SECT_MSB-`MMD_SECT_LSB:0] o_data_sector,
    output reg [`MMD_BLK_MSB-`MMD_BLK_LSB:0] o_data_block,
    output reg [`MMD_ADDR_W-`MMD_LINE_LSB-1:0] o_data_line,
    output reg o_data_ecc,
    output reg o_data_sysbus,
    output reg o_data_noopt,
    output reg o_data_trap,
    output reg o_data_wait,
    output reg o_flash_unlocked
);
    localparam [1:0] PW_LOCKED = 2'd0;
    localparam [1:0] PW_SEQ = 2'd1;
    localparam [1:0] PW_OPEN = 2'd2;
    localparam [1:0] PW_LAST = 2'd3;

    reg [1:0] pw_state;
    reg [1:0] pw_idx;
    reg [1:0] next_pw_state;
    reg [1:0] next_pw_idx;

    wire [`MMD_NTGT-1:0] f_sel;
    wire f_rsv;
    wire f_extio;
    wire [`MMD_NTGT-1:0] d_sel;
    wire d_rsv;
    wire d_extio;
    wire [`MMD_ADDR_W-1:0] gpr_addr;
    wire [`MMD_ADDR_W-1:0] d_addr;

    // byte halves: num[2:0] picks the word, num[3] picks the high byte
    assign gpr_addr = i_data_word ?
        i_cp + {19'h00000, i_gpr_num, 1'b0} :
        i_cp + {20'h00000, i_gpr_num[2:0], i_gpr_num[3]};
    assign d_addr = i_data_gpr ? gpr_addr : i_data_addr;

    // same decoder structure for both ports keeps one coherent map
    mmd_region_decode u_fetch_dec (
        .i_addr(i_fetch_addr),
        .i_has_ext_bus(i_has_ext_bus),
        .o_sel(f_sel),
        .o_reserved(f_rsv),
        .o_extio(f_extio)
    );

    mmd_region_decode u_data_dec (
        .i_addr(d_addr),
        .i_has_ext_bus(i_has_ext_bus),
        .o_sel(d_sel),
        .o_reserved(d_rsv),
        .o_extio(d_extio)
    );

    // fetch side
    wire f_flash = |f_sel[`MMD_T_FLASH3:`MMD_T_FLASH0];
    wire f_isec = (i_fetch_addr[23:12] == `MMD_ISEC_TAG);
    wire f_trap = f_sel[`MMD_T_TRAP] | (f_isec & ~i_sys_mode);
    wire f_progmem = f_flash | f_sel[`MMD_T_PROGRAM_SRAM] | f_sel[`MMD_T_EMULATED_PROGRAM_RAM];
    // untrapped fetches from anything but program memory cross the system bus
    wire f_sysbus = ~f_trap & ~f_progmem;

    // data side
    wire d_flash = |d_sel[`MMD_T_FLASH3:`MMD_T_FLASH0];
    wire d_isec = (d_addr[23:12] == `MMD_ISEC_TAG);
    wire d_program_sram_wp = i_data_wr & d_sel[`MMD_T_PROGRAM_SRAM] &
        ({1'b0, d_addr[`MMD_PROGRAM_SRAM_OFS_MSB:0]} < i_program_sram_wp_size);
    wire d_sfr_area = d_sel[`MMD_T_SFR] | d_sel[`MMD_T_EXTENDED_FUNCTION_REGS];
    wire d_dp_top = d_sel[`MMD_T_DUAL_PORT_RAM] & (d_addr[15:8] == `MMD_DP_BIT_TAG);
    wire d_bit_ok = i_data_gpr | d_sfr_area | d_dp_top;
    wire d_bit_bad = i_data_bitop & ~d_bit_ok;
    wire d_sect_wp = d_flash & i_data_wr &
        i_flash_wp[d_addr[`MMD_SECT_MSB:`MMD_SECT_LSB]];
    wire d_rd_prot = d_flash & ~i_data_wr & i_flash_rd_prot &
        (pw_state != PW_OPEN);
    wire d_trap = d_sel[`MMD_T_TRAP] | (d_isec & ~i_sys_mode) | d_bit_bad |
        d_sect_wp | d_rd_prot | d_program_sram_wp;
    wire d_progmem = d_flash | d_sel[`MMD_T_PROGRAM_SRAM] | d_sel[`MMD_T_EMULATED_PROGRAM_RAM];
    // program memory and external targets are reached over the system bus
    wire d_sysbus = ~d_trap & (d_progmem | d_sel[`MMD_T_EXT]);

    // one flash module serves one access per cycle; distinct modules overlap
    wire f_flash_go = i_fetch_req & f_flash & ~f_trap;
    wire d_flash_go = i_data_req & d_flash & ~d_trap;
    wire flash_clash = f_flash_go & d_flash_go &
        (i_fetch_addr[`MMD_MOD_MSB:`MMD_MOD_LSB] ==
         d_addr[`MMD_MOD_MSB:`MMD_MOD_LSB]);

    // password sequence; a wrong word restarts from the first
    always @* begin
        next_pw_state = pw_state;
        next_pw_idx = pw_idx;
        case (pw_state)
            PW_LOCKED,
            PW_SEQ: begin
                if (i_pw_valid) begin
                    if (i_pw_word == i_password[pw_idx*`MMD_PW_W +: `MMD_PW_W]) begin
                        if (pw_idx == PW_LAST) begin
                            next_pw_state = PW_OPEN;
                            next_pw_idx = 2'd0;
                        end else begin
                            next_pw_state = PW_SEQ;
                            next_pw_idx = pw_idx + 2'd1;
                        end
                    end else begin
                        next_pw_state = PW_LOCKED;
                        next_pw_idx = 2'd0;
                    end
                end
            end
            PW_OPEN: begin
                // unlock is only temporary
                if (i_relock) begin
                    next_pw_state = PW_LOCKED;
                    next_pw_idx = 2'd0;
                end
            end
            default: begin
                next_pw_state = PW_LOCKED;
                next_pw_idx = 2'd0;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pw_state <= PW_LOCKED;
            pw_idx <= 2'd0;
            o_flash_unlocked <= 1'b0;
        end else begin
            pw_state <= next_pw_state;
            pw_idx <= next_pw_idx;
            o_flash_unlocked <= (next_pw_state == PW_OPEN);
        end
    end

    // fetch path to the program fetch unit
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fetch_valid <= 1'b0;
            o_fetch_sel <= `MMD_SEL_NONE;
            o_fetch_addr <= 24'h000000;
            o_fetch_line <= 20'h00000;
            o_fetch_ecc <= 1'b0;
            o_fetch_sysbus <= 1'b0;
            o_fetch_noopt <= 1'b0;
            o_fetch_trap <= 1'b0;
        end else begin
            o_fetch_valid <= i_fetch_req;
            if (i_fetch_req) begin
                o_fetch_sel <= f_trap ? `MMD_SEL_TRAP : f_sel;
                o_fetch_addr <= i_fetch_addr;
                o_fetch_line <= i_fetch_addr[`MMD_ADDR_W-1:`MMD_LINE_LSB];
                o_fetch_ecc <= f_flash & ~f_trap;
                o_fetch_sysbus <= f_sysbus;
                o_fetch_noopt <= f_extio & ~f_trap;
                o_fetch_trap <= f_trap;
            end else begin
                o_fetch_sel <= `MMD_SEL_NONE;
                o_fetch_ecc <= 1'b0;
                o_fetch_sysbus <= 1'b0;
                o_fetch_noopt <= 1'b0;
                o_fetch_trap <= 1'b0;
            end
        end
    end

    // data path to the data transfer unit; a clash holds the data side
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_data_valid <= 1'b0;
            o_data_sel <= `MMD_SEL_NONE;
            o_data_addr <= 24'h000000;
            o_data_wr <= 1'b0;
            o_data_word <= 1'b0;
            o_data_bitop <= 1'b0;
            o_data_seg <= 8'h00;
            o_data_page <= 2'h0;
            o_data_sector <= 8'h00;
            o_data_block <= 5'h00;
            o_data_line <= 20'h00000;
            o_data_ecc <= 1'b0;
            o_data_sysbus <= 1'b0;
            o_data_noopt <= 1'b0;
            o_data_trap <= 1'b0;
            o_data_wait <= 1'b0;
        end else begin
            o_data_wait <= i_data_req & flash_clash;
            o_data_valid <= i_data_req & ~flash_clash;
            if (i_data_req && !flash_clash) begin
                o_data_sel <= d_trap ? `MMD_SEL_TRAP : d_sel;
                o_data_addr <= d_addr;
                o_data_wr <= i_data_wr;
                // width passes through untouched wherever the target is
                o_data_word <= i_data_word;
                o_data_bitop <= i_data_bitop & d_bit_ok;
                o_data_seg <= d_addr[`MMD_SEG_MSB:`MMD_SEG_LSB];
                o_data_page <= d_addr[`MMD_PAGE_MSB:`MMD_PAGE_LSB];
                o_data_sector <= d_addr[`MMD_SECT_MSB:`MMD_SECT_LSB];
                o_data_block <= d_addr[`MMD_BLK_MSB:`MMD_BLK_LSB];
                o_data_line <= d_addr[`MMD_ADDR_W-1:`MMD_LINE_LSB];
                o_data_ecc <= d_flash & ~d_trap & ~i_data_wr;
                o_data_sysbus <= d_sysbus;
                o_data_noopt <= d_extio & ~d_trap;
                // unused register addresses are not trapped; software keeps off them
                o_data_trap <= d_trap;
            end else begin
                o_data_sel <= `MMD_SEL_NONE;
                o_data_wr <= 1'b0;
                o_data_bitop <= 1'b0;
                o_data_ecc <= 1'b0;
                o_data_sysbus <= 1'b0;
                o_data_noopt <= 1'b0;
                o_data_trap <= 1'b0;
            end
        end
    end
endmodule // mmd_router

// ### pkg/mmd_map.vh
`ifndef MMD_MAP_VH
`define MMD_MAP_VH

// address space geometry
`define MMD_ADDR_W 24
`define MMD_SEG_W 8
`define MMD_PAGE_W 2
`define MMD_SEG_MSB 23
`define MMD_SEG_LSB 16
`define MMD_PAGE_MSB 15
`define MMD_PAGE_LSB 14

// region table, entry 0 in the low bits, ascending address order
`define MMD_NREG 20
`define MMD_REGION_LO {24'hffff00, 24'he80000, 24'he00000, 24'hcc0000, 24'hc80000, \
    24'hc40000, 24'hc00000, 24'h400000, 24'h210000, 24'h20b000, 24'h208000, 24'h204000, \
    24'h200000, 24'h010000, 24'h00fe00, 24'h00f600, 24'h00f000, 24'h00e000, 24'h00a000, \
    24'h000000}
`define MMD_REGION_HI {24'hffffff, 24'he87fff, 24'he07fff, 24'hccffff, 24'hcbffff, \
    24'hc7ffff, 24'hc3ffff, 24'hbfffff, 24'h3fffff, 24'h20bbff, 24'h20afff, 24'h205fff, \
    24'h203fff, 24'h1fffff, 24'h00ffff, 24'h00fdff, 24'h00f1ff, 24'h00efff, 24'h00dfff, \
    24'h007fff}
`define MMD_REGION_TGT {4'hc, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'hb, 4'hb, 4'hb, \
    4'hb, 4'hb, 4'hb, 4'hb, 4'h8, 4'h7, 4'h9, 4'ha, 4'h6, 4'hb}

// external io window with relaxed pipelining
`define MMD_EXTIO_LO 24'h210000
`define MMD_EXTIO_HI 24'h3fffff

// target select indices
`define MMD_NTGT 14
`define MMD_TGT_IDX_W 4
`define MMD_T_FLASH0 0
`define MMD_T_FLASH3 3
`define MMD_T_PROGRAM_SRAM 4
`define MMD_T_EMULATED_PROGRAM_RAM 5
`define MMD_T_DATA_SRAM 6
`define MMD_T_DUAL_PORT_RAM 7
`define MMD_T_SFR 8
`define MMD_T_EXTENDED_FUNCTION_REGS 9
`define MMD_T_XSFR 10
`define MMD_T_EXT 11
`define MMD_T_IMB 12
`define MMD_T_TRAP 13
`define MMD_SEL_TRAP 14'h2000
`define MMD_SEL_NONE 14'h0000

// flash geometry
`define MMD_NSECT 208
`define MMD_SECT_MSB 19
`define MMD_SECT_LSB 12
`define MMD_MOD_MSB 19
`define MMD_MOD_LSB 18
`define MMD_LINE_LSB 4
`define MMD_BLK_MSB 11
`define MMD_BLK_LSB 7
`define MMD_ISEC_TAG 12'hc0f
`define MMD_PROGRAM_SRAM_OFS_MSB 14

// dual-port ram bit-addressable top area
`define MMD_DP_BIT_TAG 8'hfd

// read-protection password
`define MMD_PW_WORDS 4
`define MMD_PW_W 16

`endif
